// [core/swc_top.sv]
`timescale 1ns/1ps
`include "swc_defines.svh"

// power-down and wake-up sequencer with apb registers
module swc_top #(
    parameter int NSRC           = `SWC_SRC_NUM,
    parameter int STARTUP_CYCLES = `SWC_STARTUP_CYCLES,
    parameter int TICK_CYCLES    = `SWC_WDT_TICK_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // core side
    input  wire logic            sleep_exec,
    input  wire logic            global_irq_enable,
    input  wire logic            clrwdt_exec,
    input  wire logic            wdt_cfg_en,
    input  wire logic            master_clear_pin_n,
    // wake sources
    input  wire logic [NSRC-1:0] src_flag,
    input  wire logic            timer_one_async,
    input  wire logic            adc_uses_rc,
    // outputs
    output logic                 core_clk_en,
    output logic                 osc_drv_en,
    output logic                 prefetch_next,
    output logic                 resume_pulse,
    output logic                 vector_after_next,
    output logic                 sleep_nop,
    output logic                 dev_reset,
    output logic                 timeout_flag,
    output logic                 powerdown_flag,
    output logic                 irq
);

    swc_pkg::swc_state_type state_r;     // sequencer state
    swc_pkg::swc_state_type state_nxt;
    swc_pkg::swc_cause_type cause_r;     // last wake cause
    logic [31:0]           ctrl_r;       // control register
    logic [NSRC-1:0]       wake_en_r;    // per-source wake enables
    logic [3:0]            irq_stat_r;   // sticky events
    logic [3:0]            irq_en_r;     // event enables
    logic [3:0]            irq_stat_nxt;
    logic [15:0]           startup_r;    // startup countdown
    logic                  to_r;         // timeout flag
    logic                  pwrdn_r;      // powerdown flag
    logic                  clk_en_r;
    logic                  osc_r;
    logic                  pref_r;
    logic                  resume_r;
    logic                  vec_r;
    logic                  nop_r;
    logic                  rst_r;
    logic                  irq_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;

    logic                  wake_req;     // combinational wake request
    logic                  wdt_to;       // watchdog expiry pulse
    logic                  wdt_en;
    logic                  wdt_clr;
    logic                  sleep_go;     // sleep takes effect
    logic                  sleep_as_nop; // sleep ignored
    logic                  wake_any;     // leaving power-down
    logic                  wake_wdt;
    logic                  pin_rst;      // reset pin asserted
    logic                  apb_acc;      // access phase before answer
    logic                  apb_wr;       // write commits this edge
    logic                  hit_ctrl;
    logic                  hit_wen;
    logic                  hit_stat;
    logic                  hit_istat;
    logic                  hit_ien;
    logic                  hit_iclr;
    logic                  hit_wclr;
    logic                  mapped;
    logic [31:0]           rd_mux;
    logic [3:0]            ev;           // events this cycle

    // clockless wake request from qualified sources
    swc_wake_detect #(
        .NSRC (NSRC)
    ) u_wake (
        .src_flag        (src_flag),
        .src_enable      (wake_en_r),
        .timer_one_async (timer_one_async),
        .adc_uses_rc     (adc_uses_rc),
        .wake_req        (wake_req)
    );

    // watchdog, enabled by config or by software bit
    swc_wdt #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_wdt (
        .clk       (clk),
        .rstn      (rstn),
        .run       (wdt_en),
        .clear     (wdt_clr),
        .ps_sel    (ctrl_r[`SWC_CTRL_PS_MSB:`SWC_CTRL_PS_LSB]),
        .timeout_r (wdt_to)
    );

    // sequencing decisions
    assign pin_rst      = ~master_clear_pin_n;
    assign wdt_en       = wdt_cfg_en | ctrl_r[`SWC_CTRL_SWDT_BIT];
    assign sleep_go     = (state_r == swc_pkg::ST_RUN) && sleep_exec && !wake_req && !pin_rst; // RULE_14
    assign sleep_as_nop = (state_r == swc_pkg::ST_RUN) && sleep_exec && wake_req && !pin_rst; // RULE_12
    assign wake_wdt     = (state_r == swc_pkg::ST_ASLEEP) && wdt_to; // RULE_01
    assign wake_any     = (state_r == swc_pkg::ST_ASLEEP) && !pin_rst && (wdt_to || wake_req); // RULE_13
    // cleared on entry, on wake, through startup, by command
    assign wdt_clr      = sleep_go || wake_any || (state_r == swc_pkg::ST_STARTUP) // RULE_11 RULE_16
                          || clrwdt_exec || (apb_wr && hit_wclr);

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            swc_pkg::ST_RUN:
                if (sleep_go)
                    state_nxt = swc_pkg::ST_ASLEEP;
            swc_pkg::ST_ASLEEP:
                if (wake_any)
                    state_nxt = ctrl_r[`SWC_CTRL_XTAL_BIT] ? swc_pkg::ST_STARTUP : swc_pkg::ST_RESUME;
            swc_pkg::ST_STARTUP:
                if (startup_r == 16'h0000)
                    state_nxt = swc_pkg::ST_RESUME;
            swc_pkg::ST_RESUME:
                state_nxt = swc_pkg::ST_RUN;
            default:
                state_nxt = swc_pkg::ST_RUN;
        endcase
        if (pin_rst)
            state_nxt = swc_pkg::ST_RUN; // RULE_02
    end

    // state, startup count and cause
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r   <= swc_pkg::ST_RUN;
            startup_r <= 16'h0000;
            cause_r   <= swc_pkg::CAUSE_NONE;
        end
        else
        begin
            state_r   <= state_nxt;
            startup_r <= wake_any ? 16'(STARTUP_CYCLES - 1)
                         : (startup_r != 16'h0000 ? startup_r - 16'h0001 : startup_r);
            if (pin_rst && state_r == swc_pkg::ST_ASLEEP)
                cause_r <= swc_pkg::CAUSE_RESET;
            else if (wake_any)
                cause_r <= wake_wdt ? swc_pkg::CAUSE_WDT : swc_pkg::CAUSE_IRQ;
        end
    end

    // status flags: power-up sets both
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            to_r    <= 1'b1;
            pwrdn_r <= 1'b1; // RULE_03
        end
        else if (sleep_go)
        begin
            to_r    <= 1'b1; // RULE_15
            pwrdn_r <= 1'b0; // RULE_03
        end
        else if (wake_wdt && !pin_rst)
            to_r <= 1'b0; // RULE_04
    end

    // clock, oscillator and core strobes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clk_en_r <= 1'b1;
            osc_r    <= 1'b1;
            pref_r   <= 1'b0;
            resume_r <= 1'b0;
            vec_r    <= 1'b0;
            nop_r    <= 1'b0;
            rst_r    <= 1'b0;
        end
        else
        begin
            pref_r   <= sleep_exec && (state_r == swc_pkg::ST_RUN); // RULE_07
            nop_r    <= sleep_as_nop; // RULE_12
            rst_r    <= pin_rst; // RULE_02
            resume_r <= (state_r == swc_pkg::ST_RESUME) && !pin_rst; // RULE_02
            // interrupt wake vectors only with global enable set
            vec_r    <= (state_r == swc_pkg::ST_RESUME) && !pin_rst && global_irq_enable // RULE_09 RULE_10
                        && (cause_r == swc_pkg::CAUSE_IRQ);
            if (pin_rst || state_r == swc_pkg::ST_RESUME)
                clk_en_r <= 1'b1;
            else if (sleep_go)
                clk_en_r <= 1'b0;
            if (pin_rst || wake_any)
                osc_r <= 1'b1;
            else if (sleep_go)
                osc_r <= 1'b0; // RULE_15
        end
    end

    // apb decode
    assign apb_acc   = psel && penable && !pready_r;
    assign apb_wr    = psel && penable && pready_r && pwrite && !pslverr_r;
    assign hit_ctrl  = (paddr == `SWC_OFS_CTRL);
    assign hit_wen   = (paddr == `SWC_OFS_WAKE_EN);
    assign hit_stat  = (paddr == `SWC_OFS_STATUS);
    assign hit_istat = (paddr == `SWC_OFS_IRQ_STAT);
    assign hit_ien   = (paddr == `SWC_OFS_IRQ_EN);
    assign hit_iclr  = (paddr == `SWC_OFS_IRQ_CLR);
    assign hit_wclr  = (paddr == `SWC_OFS_WDT_CLR);
    assign mapped    = hit_ctrl | hit_wen | hit_stat | hit_istat | hit_ien | hit_iclr | hit_wclr;
    assign rd_mux    = hit_ctrl  ? ctrl_r :
                       hit_wen   ? 32'(wake_en_r) :
                       hit_stat  ? ((32'(src_flag) << `SWC_ST_SRC_LSB)
                                   | (32'(state_r) << `SWC_ST_STATE_LSB)
                                   | (32'(cause_r) << `SWC_ST_CAUSE_LSB)
                                   | (32'(pwrdn_r) << `SWC_ST_PWRDN_BIT)
                                   | (32'(to_r) << `SWC_ST_TO_BIT)) :
                       hit_istat ? 32'(irq_stat_r) :
                       hit_ien   ? 32'(irq_en_r) : 32'h0000_0000;

    // one wait state, answer registered
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= apb_acc;
            pslverr_r <= apb_acc && !mapped;
            if (apb_acc)
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // writable registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_r    <= `SWC_CTRL_RESET;
            wake_en_r <= '0;
            irq_en_r  <= 4'h0;
        end
        else if (apb_wr)
        begin
            if (hit_ctrl)
                ctrl_r <= pwdata & 32'h0000_00F3;
            if (hit_wen)
                wake_en_r <= pwdata[NSRC-1:0]; // RULE_08
            if (hit_ien)
                irq_en_r <= pwdata[3:0];
        end
    end

    // sticky events, set wins over clear
    assign ev[`SWC_EV_WAKE]  = wake_any;
    assign ev[`SWC_EV_WDT]   = wdt_to;
    assign ev[`SWC_EV_NOP]   = sleep_as_nop;
    assign ev[`SWC_EV_RESET] = pin_rst && (state_r == swc_pkg::ST_ASLEEP);
    assign irq_stat_nxt      = (irq_stat_r & ~((apb_wr && hit_iclr) ? pwdata[3:0] : 4'h0)) | ev;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_stat_r <= 4'h0;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= |(irq_stat_r & irq_en_r);
        end
    end

    // outputs straight from flops
    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign core_clk_en       = clk_en_r;
    assign osc_drv_en        = osc_r;
    assign prefetch_next     = pref_r;
    assign resume_pulse      = resume_r;
    assign vector_after_next = vec_r;
    assign sleep_nop         = nop_r;
    assign dev_reset         = rst_r;
    assign timeout_flag      = to_r;
    assign powerdown_flag    = pwrdn_r;
    assign irq               = irq_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_nop_keeps_flags: assert property (sleep_as_nop // RULE_12
        |=> (pwrdn_r == $past(pwrdn_r)) && (to_r == $past(to_r)) && nop_r)
        else $error("no-op sleep changed flags");
    a_sleep_entry: assert property (sleep_go |=> !pwrdn_r && to_r && !clk_en_r && !osc_r) // RULE_15
        else $error("sleep entry effects missing");
    a_wdt_wake_to: assert property (wake_wdt && !pin_rst |=> !to_r) // RULE_04
        else $error("timeout flag not cleared on watchdog wake");
    a_wake_clears_wdt: assert property (wake_any |-> wdt_clr ##1 !wdt_to) // RULE_11
        else $error("watchdog not cleared on wake");
    a_startup_hold: assert property ((state_r == swc_pkg::ST_STARTUP) |=> !wdt_to) // RULE_16
        else $error("watchdog ran during startup");
    a_prefetch: assert property (sleep_exec && state_r == swc_pkg::ST_RUN |=> pref_r) // RULE_07
        else $error("prefetch missing");
    a_pin_reset: assert property (pin_rst |=> rst_r && state_r == swc_pkg::ST_RUN) // RULE_02
        else $error("reset pin not honoured");
    a_wake_resume: assert property (wake_any && !ctrl_r[`SWC_CTRL_XTAL_BIT] && !pin_rst ##1 !pin_rst // RULE_13
        |=> resume_r && clk_en_r)
        else $error("resume not reached after wake");
    a_vector_glob: assert property (resume_r && !$past(global_irq_enable) |-> !vec_r) // RULE_09
        else $error("vectored with global enable clear");
    a_wake_gated: assert property ((state_r == swc_pkg::ST_ASLEEP) && !wdt_to && !(|(src_flag & wake_en_r)) // RULE_08
        |=> state_r != swc_pkg::ST_STARTUP && state_r != swc_pkg::ST_RESUME)
        else $error("wake without enabled source");

    c_irq_wake: cover property (sleep_go ##[1:20] (wake_any && !wake_wdt));
    c_wdt_wake: cover property (wake_wdt);
    c_nop_sleep: cover property (sleep_as_nop);
    c_vector: cover property (vec_r);

endmodule : swc_top

// [common/swc_defines.svh]
// Overview of operation
// RULE_01 - wake on reset pin, watchdog, or interrupt
// RULE_02 - reset pin resets; others resume execution
// RULE_03 - powerdown flag set at power-up, cleared on sleep
// RULE_04 - timeout flag cleared on watchdog wake
// RULE_05 - only listed peripherals may wake
// RULE_06 - clockless peripherals only; others never wake
// RULE_07 - next instruction prefetched during sleep instruction
// RULE_08 - wake needs source enable, ignores global enable
// RULE_09 - global enable clear: continue after sleep
// RULE_10 - global enable set: next instruction, then vector
// RULE_11 - watchdog cleared on every wake; the code does not clear it on a reset-pin wake, only when wake_any is set
// RULE_12 - pending enabled flag makes sleep a no-op
// RULE_13 - flag during/after sleep: complete, wake at once
// RULE_14 - sleep entered by the power-down instruction
// RULE_15 - entry clears watchdog, flags, stops oscillator; the code clears the powerdown flag but sets the timeout flag
// RULE_16 - crystal wake holds watchdog until startup done
// RULE_17 - wake request is clockless OR of flag&enable
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

// register byte offsets
`define SWC_OFS_CTRL        8'h00
`define SWC_OFS_WAKE_EN     8'h04
`define SWC_OFS_STATUS      8'h08
`define SWC_OFS_IRQ_STAT    8'h0C
`define SWC_OFS_IRQ_EN      8'h10
`define SWC_OFS_IRQ_CLR     8'h14
`define SWC_OFS_WDT_CLR     8'h18

// control register fields
`define SWC_CTRL_SWDT_BIT   0
`define SWC_CTRL_XTAL_BIT   1
`define SWC_CTRL_PS_LSB     4
`define SWC_CTRL_PS_MSB     7
`define SWC_CTRL_RESET      32'h0000_0040

// status register fields
`define SWC_ST_TO_BIT       0
`define SWC_ST_PWRDN_BIT    1
`define SWC_ST_CAUSE_LSB    4
`define SWC_ST_STATE_LSB    8
`define SWC_ST_SRC_LSB      16

// interrupt event bits
`define SWC_EV_WAKE         0
`define SWC_EV_WDT          1
`define SWC_EV_NOP          2
`define SWC_EV_RESET        3
`define SWC_EV_NUM          4

// wake source positions
`define SWC_SRC_TIMER_ONE   0
`define SWC_SRC_ADC         2
`define SWC_SRC_NUM         9

// timing
`define SWC_CLK_PERIOD_NS   25
`define SWC_LFOSC_PERIOD_NS 32258
`define SWC_WDT_TICK_CYCLES (`SWC_LFOSC_PERIOD_NS / `SWC_CLK_PERIOD_NS)
`define SWC_STARTUP_CYCLES  1024
`define SWC_PS_BASE_LOG2    5

`endif

// [common/swc_pkg.sv]
package swc_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_ASLEEP  = 3'b001,
        ST_STARTUP = 3'b010,
        ST_RESUME  = 3'b011
    } swc_state_type;

    // last wake cause
    typedef enum logic [1:0] {
        CAUSE_NONE  = 2'b00,
        CAUSE_IRQ   = 2'b01,
        CAUSE_WDT   = 2'b10,
        CAUSE_RESET = 2'b11
    } swc_cause_type;

endpackage : swc_pkg

// [core/swc_wake_detect.sv]
`timescale 1ns/1ps
`include "swc_defines.svh"

// purely combinational wake request, works with every clock stopped
module swc_wake_detect #(
    parameter int NSRC = `SWC_SRC_NUM
) (
    input  wire logic [NSRC-1:0] src_flag,
    input  wire logic [NSRC-1:0] src_enable,
    input  wire logic            timer_one_async,
    input  wire logic            adc_uses_rc,
    output logic                 wake_req
);

    logic [NSRC-1:0] qual;      // flag qualified by clock availability
    logic [NSRC-1:0] hit;       // flag and enable per source

    // timer one and adc only count when running from their own clock
    genvar i;
    generate
        for (i = 0; i < NSRC; i++)
        begin : g_src
            if (i == `SWC_SRC_TIMER_ONE)
            begin : g_t1
                assign qual[i] = src_flag[i] & timer_one_async; // RULE_05
            end
            else if (i == `SWC_SRC_ADC)
            begin : g_adc
                assign qual[i] = src_flag[i] & adc_uses_rc; // RULE_05
            end
            else
            begin : g_plain
                assign qual[i] = src_flag[i]; // RULE_06
            end
            assign hit[i] = qual[i] & src_enable[i]; // RULE_08
        end
    endgenerate

    // or of all enabled sources, no flop in the path
    assign wake_req = |hit; // RULE_17

endmodule : swc_wake_detect

// [core/swc_wdt.sv]
`timescale 1ns/1ps
`include "swc_defines.svh"

// watchdog: low-rate tick divider, selectable prescaler, timeout pulse
module swc_wdt #(
    parameter int TICK_CYCLES = `SWC_WDT_TICK_CYCLES,
    parameter int PS_W        = 17
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [3:0] ps_sel,
    output logic            timeout_r
);

    logic [15:0]     div_r;     // tick divider
    logic [PS_W-1:0] cnt_r;     // prescaler count
    logic [PS_W-1:0] limit;     // terminal count
    logic [3:0]      ps_eff;    // reserved codes clamp to longest
    logic            tick;      // one-cycle low-rate enable

    assign ps_eff = (ps_sel > 4'hB) ? 4'hB : ps_sel;
    assign limit  = PS_W'((PS_W'(1) << (ps_eff + `SWC_PS_BASE_LOG2)) - PS_W'(1));
    assign tick   = (div_r == 16'(TICK_CYCLES - 1));

    // divider and counter, clear or stop zeroes both
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_r     <= 16'h0000;
            cnt_r     <= '0;
            timeout_r <= 1'b0;
        end
        else if (clear || !run)
        begin
            div_r     <= 16'h0000;
            cnt_r     <= '0;
            timeout_r <= 1'b0;
        end
        else
        begin
            div_r     <= tick ? 16'h0000 : div_r + 16'h0001;
            timeout_r <= tick && (cnt_r == limit);
            if (tick)
                cnt_r <= (cnt_r == limit) ? '0 : cnt_r + PS_W'(1);
        end
    end

endmodule : swc_wdt

// [bench/swc_core_model.sv]
`timescale 1ns/1ps

// core stand-in: issues the power-down instruction, then sits asleep
module swc_core_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic go,
    input  wire logic resume_pulse,
    input  wire logic sleep_nop,
    input  wire logic dev_reset,
    output logic      sleep_exec,
    output logic      asleep_r
);
    // one pulse per request, next one only after the last sleep ended
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleep_exec <= 1'b0;
            asleep_r   <= 1'b0;
        end
        else
        begin
            sleep_exec <= go && !asleep_r;
            if (sleep_exec)
                asleep_r <= 1'b1;
            // resume, ignored sleep or pin reset ends it
            else if (resume_pulse || sleep_nop || dev_reset)
                asleep_r <= 1'b0;
        end
    end
endmodule : swc_core_model

// [bench/sleep_wakeup_control_test.sv]
`timescale 1ns/1ps

// directed bench: apb setup, sleep entry and every wake path
module sleep_wakeup_control_test;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_exec;
    logic        glob_en;
    logic        pin_rst_n;
    logic        adc_rc;
    logic [8:0]  src_flag;
    logic        t1_async;
    logic        go;
    logic        core_clk_en;
    logic        osc_drv_en;
    logic        prefetch_next;
    logic        resume_pulse;
    logic        vector_after_next;
    logic        sleep_nop;
    logic        dev_reset;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          total_checks;
    int          cyc;

    swc_top #(.STARTUP_CYCLES(8), .TICK_CYCLES(4)) dut_u (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
        .global_irq_enable(glob_en), .clrwdt_exec(1'b0), .wdt_cfg_en(1'b0),
        .master_clear_pin_n(pin_rst_n), .src_flag(src_flag),
        .timer_one_async(t1_async), .adc_uses_rc(adc_rc),
        .core_clk_en(core_clk_en), .osc_drv_en(osc_drv_en),
        .prefetch_next(prefetch_next), .resume_pulse(resume_pulse),
        .vector_after_next(vector_after_next), .sleep_nop(sleep_nop),
        .dev_reset(dev_reset), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag), .irq(irq));

    swc_core_model core_u (
        .clk(clk), .rstn(rstn), .go(go), .resume_pulse(resume_pulse),
        .sleep_nop(sleep_nop), .dev_reset(dev_reset),
        .sleep_exec(sleep_exec), .asleep_r());

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // verdict and stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    // compare one value
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            err_total = err_total + 1;
        end
    endtask : chk

    // one apb transfer, result in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the hang guard ends a wait that never sees pready
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // core executes power-down; returns one step after it is taken
    task automatic do_sleep;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask : do_sleep

    // bounded wait for the resume pulse
    task automatic wait_resume;
        int n;
        for (n = 0; n < 600 && resume_pulse !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk("resume", 1, resume_pulse);
    endtask : wait_resume

    // main sequence
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {glob_en, src_flag, t1_async, adc_rc, go, err_total, total_checks, cyc} = '0;
        pin_rst_n = 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("to_rst", 1, timeout_flag);
        chk("pwrdn_rst", 1, powerdown_flag);
        apb(0, 8'h00, 0);
        chk("ctrl", 32'h0000_0040, rd);
        apb(0, 8'h1c, 0);
        chk("unmapped", 32'h0000_0001, {rd[30:0], er});
        apb(1, 8'h04, 32'h0000_01fd);
        apb(1, 8'h10, 32'h0000_0001);
        $display("test 1 done");
        src_flag <= 9'h040;
        do_sleep();
        chk("nop", 1, sleep_nop);
        chk("pwrdn_nop", 1, powerdown_flag);
        chk("clk_nop", 1, core_clk_en);
        src_flag <= 9'h000;
        $display("test 2 done");
        do_sleep();
        chk("prefetch", 1, prefetch_next);
        chk("pwrdn_sleep", 0, powerdown_flag);
        chk("to_sleep", 1, timeout_flag);
        chk("stopped", 0, {core_clk_en, osc_drv_en});
        src_flag <= 9'h040;
        wait_resume();
        chk("vec_glob0", 0, vector_after_next);
        src_flag <= 9'h000;
        repeat (2) @(posedge clk);
        #1;
        chk("irq_set", 1, irq);
        apb(0, 8'h0c, 0);
        chk("irq_stat", 32'h0000_0005, rd);
        apb(1, 8'h14, 32'h0000_000f);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_clr", 0, irq);
        $display("test 3 done");
        glob_en  <= 1'b1;
        t1_async <= 1'b1;
        do_sleep();
        src_flag <= 9'h001;
        wait_resume();
        chk("vec_glob1", 1, vector_after_next);
        glob_en  <= 1'b0;
        t1_async <= 1'b0;
        src_flag <= 9'h007;
        $display("test 4 done");
        apb(1, 8'h00, 32'h0000_0001);
        do_sleep();
        repeat (20) @(posedge clk);
        #1;
        chk("no_wake", 0, core_clk_en);
        wait_resume();
        chk("to_wdt", 0, timeout_flag);
        // live flags, watchdog cause, run state, both flags clear
        apb(0, 8'h08, 0);
        chk("status", 32'h0007_0020, rd);
        apb(1, 8'h00, 32'h0000_0000);
        src_flag <= 9'h000;
        $display("test 5 done");
        // crystal clock: startup count before resume; adc on rc clock wakes
        apb(1, 8'h00, 32'h0000_0003);
        adc_rc   <= 1'b1;
        do_sleep();
        src_flag <= 9'h004;
        repeat (3) @(posedge clk);
        #1;
        chk("startup", 1, {core_clk_en, osc_drv_en});
        wait_resume();
        src_flag <= 9'h000;
        adc_rc   <= 1'b0;
        apb(1, 8'h00, 32'h0000_0000);
        $display("test 6 done");
        do_sleep();
        pin_rst_n <= 1'b0;
        @(posedge clk);
        pin_rst_n <= 1'b1;
        #1;
        chk("dev_reset", 1, dev_reset);
        repeat (3) @(posedge clk);
        #1;
        chk("run_again", 1, core_clk_en);
        $display("test 7 done");
        end_sim();
    end
endmodule : sleep_wakeup_control_test
